//--- hw/ehb_pkg.sv
package ehb_pkg;
  localparam int EHB_AW = 11;
  localparam int EHB_DW = 8;
  localparam int EHB_FIFO_DEPTH = 16;
  // Local register indices on the CPU side port.
  localparam logic [3:0] EHB_IDX_ENABLE = 4'h0;
  localparam logic [3:0] EHB_IDX_CFG_LO = 4'h1;
  localparam logic [3:0] EHB_IDX_CFG_HI = 4'h2;
  localparam logic [3:0] EHB_IDX_BUF = 4'h3;
  localparam logic [3:0] EHB_IDX_MODE = 4'h4;
  localparam logic [3:0] EHB_IDX_ADDR_LO = 4'h5;
  localparam logic [3:0] EHB_IDX_ADDR_HI = 4'h6;
  localparam logic [3:0] EHB_IDX_END_LO = 4'h7;
  localparam logic [3:0] EHB_IDX_END_HI = 4'h8;
  localparam logic [3:0] EHB_IDX_STATUS = 4'h9;
  // Field positions.
  localparam int EHB_EN_RX = 0;
  localparam int EHB_EN_TX = 1;
  localparam int EHB_EN_MC = 2;
  localparam int EHB_CFG_INT_LSB = 1;
  localparam int EHB_CFG_A1 = 4;
  localparam int EHB_CFG_DRQ_LSB = 0;
  localparam int EHB_CFG_DACK = 2;
  localparam int EHB_CFG_TC = 3;
  localparam int EHB_MODE_RX = 0;
  localparam int EHB_MODE_TX = 1;
  localparam int EHB_MODE_BURST = 2;
  // Pin output selections.
  localparam logic [1:0] EHB_SEL_TX = 2'h0;
  localparam logic [1:0] EHB_SEL_RX = 2'h1;
  localparam logic [1:0] EHB_SEL_MREQ = 2'h2;
  localparam logic [1:0] EHB_DRQ_PORT = 2'h0;
  // Reset values.
  localparam logic [7:0] EHB_RST_BYTE = 8'h00;
  localparam logic [10:0] EHB_RST_ADDR = 11'h000;
  // Buffer to RAM move, and the worst wait while the USB side has the RAM.
  localparam int EHB_XFER_CLKS = 2;
  localparam int EHB_RAM_WAIT_MAX = 2;
  typedef enum logic [1:0] {
    EHB_MC_OFF = 2'h0,
    EHB_MC_RUN = 2'h1,
    EHB_MC_END = 2'h3
  } ehb_mc_type;
  typedef struct packed {
    logic cs_n;
    logic a0;
    logic rd_n;
    logic wr_n;
    logic dack_n;
    logic tc;
    logic a1;
  } ehb_pins_type;
  localparam ehb_pins_type EHB_PINS_IDLE = 7'h5c;
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } ehb_ram_word_type;
endpackage : ehb_pkg

//--- hw/ehb_port.sv
// How it works
// - Channel line high: processor path, raise interrupt.
// - Channel line low: RAM access, address auto-increments.
// - DMA acknowledge low acts as memory-path select.
// - Rising strobe edge launches the RAM transfer.
// - Counter loads only while memory path disabled.
// - Last-byte input on write ends transfer, status 11.
// - Counter keeps its final value after the end.
// - Interrupt pin selects tx, rx or request.
// - DMA request pin is a port after reset.
// - Cycle mode: one request pulse per byte.
// - Burst mode: request held from start to end unless the rx FIFO is full.
// - Each DMA pin individually port or DMA function.
// - Status select pin is a port until enabled.
// - Both paths share one tx and rx byte.
// - Memory path gated by config and path state.
// - Enable bits gate processor-path commands and flags.
// - Interrupt source register is read-only status.
// - Register strobes from address decode and read/write.
// - Buffer to RAM move within two clocks plus waits.
// - Status 00 when disabled, 11 at end.
// - Ready flags clear on buffer access or disable.
// - Status select high returns source register to host.
`timescale 1ns/10ps

module ehb_fifo #(
  parameter int W = 19,
  parameter int D = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = $clog2(D);
  if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
    $error("ehb_fifo depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  wire full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  wire empty = wr_q == rd_q;
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_q[PW-1:0]];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (PW + 1)'(push);
      rd_q <= rd_q + (PW + 1)'(pop);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q[PW-1:0]] <= i_in_data;
    end
  end
endmodule : ehb_fifo

module ehb_port
  import ehb_pkg::*;
#(
  parameter int FIFO_DEPTH = EHB_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_host_select_n,
  input wire logic i_channel_select_line,
  input wire logic i_host_read_n,
  input wire logic i_host_write_n,
  input wire logic i_dma_acknowledge_n,
  input wire logic i_transfer_last_byte_in,
  input wire logic i_status_read_select,
  input wire logic [7:0] i_host_data_bus,
  output logic [7:0] o_host_data_bus,
  output logic o_host_data_oe_n,
  output logic o_host_interrupt_out,
  output logic o_dma_request_out,
  input wire logic i_cpu_sel,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_wr,
  input wire logic [3:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  output logic o_cpu_irq,
  output logic o_ram_req,
  output logic o_ram_we,
  output logic [10:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  input wire logic i_ram_grant,
  input wire logic [7:0] i_ram_rdata
);
  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("ehb_port needs a FIFO of at least two words");
  end

  function automatic logic wstb(input logic [3:0] idx, input logic sel,
                                input logic wr, input logic [3:0] a);
    return sel && wr && (a == idx);
  endfunction : wstb

  function automatic logic pick(input logic [1:0] s, input logic tx,
                                input logic rx, input logic rq);
    return (s == EHB_SEL_TX) ? tx : (s == EHB_SEL_RX) ? rx :
           (s == EHB_SEL_MREQ) ? rq : 1'b0;
  endfunction : pick

  ehb_pins_type pins_m_q;
  ehb_pins_type pins_s_q;
  ehb_pins_type pins_p_q;
  logic [7:0] dat_m_q;
  logic [7:0] dat_s_q;
  logic [7:0] dat_p_q;
  logic [2:0] enable_q;
  logic [7:0] cfg_lo_q;
  logic [7:0] cfg_hi_q;
  logic [7:0] mode_q;
  logic [10:0] addr_q;
  logic [10:0] end_q;
  ehb_mc_type mc_q;
  logic rx_rdy_q;
  logic tx_rdy_q;
  logic mtx_full_q;
  logic [7:0] rx_buf_q;
  logic [7:0] tx_buf_q;
  logic mreq_q;
  logic [7:0] rdata_d;
  logic fifo_in_ready;
  logic fifo_out_valid;
  ehb_ram_word_type fifo_out;

  wire ehb_pins_type pins_raw = '{cs_n: i_host_select_n,
    a0: i_channel_select_line, rd_n: i_host_read_n, wr_n: i_host_write_n,
    dack_n: i_dma_acknowledge_n, tc: i_transfer_last_byte_in,
    a1: i_status_read_select};

  // Strobe edges come from the second and third stages only.
  wire rd_rise = !pins_p_q.rd_n && pins_s_q.rd_n;
  wire wr_rise = !pins_p_q.wr_n && pins_s_q.wr_n;
  wire rx_en = enable_q[EHB_EN_RX];
  wire tx_en = enable_q[EHB_EN_TX];
  wire mc_en = enable_q[EHB_EN_MC];
  wire dack_fn = cfg_hi_q[EHB_CFG_DACK];
  wire tc_on = cfg_hi_q[EHB_CFG_TC] && pins_p_q.tc;
  wire a1_fn = cfg_lo_q[EHB_CFG_A1];
  wire [1:0] int_sel = cfg_lo_q[EHB_CFG_INT_LSB+:2];
  wire [1:0] drq_sel = cfg_hi_q[EHB_CFG_DRQ_LSB+:2];
  wire burst = mode_q[EHB_MODE_BURST];
  wire running = mc_q == EHB_MC_RUN;

  // The host must keep the channel line low under acknowledge.
  wire cch_sel = !pins_p_q.cs_n && pins_p_q.a0;
  wire mch_sel = mc_en && ((!pins_p_q.cs_n && !pins_p_q.a0) ||
                 (dack_fn && !pins_p_q.dack_n));
  wire cch_wr = wr_rise && cch_sel && rx_en;
  wire cch_rd = rd_rise && cch_sel && tx_en;
  wire mem_path_rx_allowed = running && mode_q[EHB_MODE_RX] &&
                             fifo_in_ready;
  wire mem_path_tx_allowed = running && mode_q[EHB_MODE_TX] &&
                             mtx_full_q;
  wire mch_wr = wr_rise && mch_sel && mem_path_rx_allowed;
  wire mch_rd = rd_rise && mch_sel && mem_path_tx_allowed;
  wire mch_step = mch_wr || mch_rd;
  wire mem_path_final_cmd = (mch_wr && tc_on) ||
                            (mch_step && addr_q == end_q);
  wire mem_path_tx_buffer_ctl = mc_en && mode_q[EHB_MODE_TX];
  wire fetch_want = running && mode_q[EHB_MODE_TX] && !mtx_full_q;
  wire fetch_done = fetch_want && !fifo_out_valid && i_ram_grant;
  wire rd_buf = i_cpu_sel && i_cpu_rd && i_cpu_addr == EHB_IDX_BUF;
  wire wr_buf = wstb(EHB_IDX_BUF, i_cpu_sel, i_cpu_wr, i_cpu_addr);
  wire host_busy = !pins_s_q.rd_n || !pins_s_q.wr_n;
  wire mreq_d = burst ? (running && !(mode_q[EHB_MODE_RX] &&
                !fifo_in_ready))
              : ((mem_path_rx_allowed || mem_path_tx_allowed) &&
                !host_busy);
  wire [7:0] status = {4'h0, mc_q, tx_rdy_q, rx_rdy_q};
  wire stat_sel = a1_fn && pins_s_q.a1;
  wire drive = !pins_s_q.rd_n && (!pins_s_q.cs_n ||
               (dack_fn && !pins_s_q.dack_n));

  assign o_ram_req = fifo_out_valid || fetch_want;
  assign o_ram_we = fifo_out_valid;
  assign o_ram_addr = fifo_out_valid ? fifo_out.addr : addr_q;
  assign o_ram_wdata = fifo_out.data;

  ehb_fifo #(
    .W($bits(ehb_ram_word_type)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(mch_wr),
    .o_in_ready(fifo_in_ready),
    .i_in_data({addr_q, dat_p_q}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_ram_grant),
    .o_out_data(fifo_out)
  );

  always_comb begin
    case (i_cpu_addr)
      EHB_IDX_ENABLE: rdata_d = {5'h00, enable_q};
      EHB_IDX_CFG_LO: rdata_d = cfg_lo_q;
      EHB_IDX_CFG_HI: rdata_d = cfg_hi_q;
      EHB_IDX_BUF: rdata_d = rx_buf_q;
      EHB_IDX_MODE: rdata_d = mode_q;
      EHB_IDX_ADDR_LO: rdata_d = addr_q[7:0];
      EHB_IDX_ADDR_HI: rdata_d = {5'h00, addr_q[10:8]};
      EHB_IDX_END_LO: rdata_d = end_q[7:0];
      EHB_IDX_END_HI: rdata_d = {5'h00, end_q[10:8]};
      EHB_IDX_STATUS: rdata_d = status;
      default: rdata_d = EHB_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pins_m_q <= EHB_PINS_IDLE;
      pins_s_q <= EHB_PINS_IDLE;
      pins_p_q <= EHB_PINS_IDLE;
      dat_m_q <= EHB_RST_BYTE;
      dat_s_q <= EHB_RST_BYTE;
      dat_p_q <= EHB_RST_BYTE;
    end else begin
      pins_m_q <= pins_raw;
      pins_s_q <= pins_m_q;
      pins_p_q <= pins_s_q;
      dat_m_q <= i_host_data_bus;
      dat_s_q <= dat_m_q;
      dat_p_q <= dat_s_q;
    end
  end

  // Pin functions come out of reset as ports, except the interrupt pin, which selects tx ready.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      enable_q <= 3'h0;
      cfg_lo_q <= EHB_RST_BYTE;
      cfg_hi_q <= EHB_RST_BYTE;
      mode_q <= EHB_RST_BYTE;
      end_q <= EHB_RST_ADDR;
    end else begin
      if (wstb(EHB_IDX_ENABLE, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        enable_q <= i_cpu_wdata[2:0];
      if (wstb(EHB_IDX_CFG_LO, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        cfg_lo_q <= i_cpu_wdata;
      if (wstb(EHB_IDX_CFG_HI, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        cfg_hi_q <= i_cpu_wdata;
      if (wstb(EHB_IDX_MODE, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        mode_q <= i_cpu_wdata;
      if (wstb(EHB_IDX_END_LO, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        end_q[7:0] <= i_cpu_wdata;
      if (wstb(EHB_IDX_END_HI, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        end_q[10:8] <= i_cpu_wdata[2:0];
    end
  end

  // The counter is left at its last value when the transfer ends.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      addr_q <= EHB_RST_ADDR;
    end else if (mch_step) begin
      addr_q <= addr_q + 11'h001;
    end else if (!mc_en) begin
      if (wstb(EHB_IDX_ADDR_LO, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        addr_q[7:0] <= i_cpu_wdata;
      if (wstb(EHB_IDX_ADDR_HI, i_cpu_sel, i_cpu_wr, i_cpu_addr))
        addr_q[10:8] <= i_cpu_wdata[2:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mc_q <= EHB_MC_OFF;
    end else begin
      case (mc_q)
        EHB_MC_OFF: mc_q <= mc_en ? EHB_MC_RUN : EHB_MC_OFF;
        EHB_MC_RUN: begin
          if (!mc_en) mc_q <= EHB_MC_OFF;
          else if (mem_path_final_cmd) mc_q <= EHB_MC_END;
        end
        EHB_MC_END: if (!mc_en) mc_q <= EHB_MC_OFF;
        default: mc_q <= EHB_MC_OFF;
      endcase
    end
  end

  // A host access beats a software clear in the same cycle.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rx_rdy_q <= 1'b0;
      tx_rdy_q <= 1'b0;
      mtx_full_q <= 1'b0;
    end else begin
      if (cch_wr) rx_rdy_q <= 1'b1;
      else if (!rx_en || rd_buf) rx_rdy_q <= 1'b0;
      if (cch_rd) tx_rdy_q <= 1'b1;
      else if (!tx_en || wr_buf) tx_rdy_q <= 1'b0;
      if (fetch_done) mtx_full_q <= 1'b1;
      else if (mch_rd || !running) mtx_full_q <= 1'b0;
    end
  end

  // One byte each way, shared by both paths.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rx_buf_q <= EHB_RST_BYTE;
      tx_buf_q <= EHB_RST_BYTE;
    end else begin
      if (cch_wr || mch_wr) rx_buf_q <= dat_p_q;
      if (fetch_done) tx_buf_q <= i_ram_rdata;
      else if (wr_buf && !mem_path_tx_buffer_ctl)
        tx_buf_q <= i_cpu_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mreq_q <= 1'b0;
      o_host_interrupt_out <= 1'b0;
      o_dma_request_out <= 1'b0;
      o_cpu_irq <= 1'b0;
      o_cpu_rdata <= EHB_RST_BYTE;
      o_host_data_bus <= EHB_RST_BYTE;
      o_host_data_oe_n <= 1'b1;
    end else begin
      mreq_q <= mreq_d;
      o_host_interrupt_out <= pick(int_sel, tx_rdy_q, rx_rdy_q,
                                   mreq_q);
      o_dma_request_out <= (drq_sel == EHB_DRQ_PORT) ? 1'b0 :
        pick(drq_sel, 1'b0, rx_rdy_q, mreq_q);
      o_cpu_irq <= cch_wr || cch_rd ||
                   (running && mem_path_final_cmd);
      o_cpu_rdata <= (i_cpu_sel && i_cpu_rd) ? rdata_d
                     : EHB_RST_BYTE;
      o_host_data_bus <= stat_sel ? status : tx_buf_q;
      o_host_data_oe_n <= !drive;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  cch_irq_a: assert property (cch_wr |=> o_cpu_irq && rx_rdy_q)
    else $error("processor path write raised no interrupt");
  mch_count_a: assert property (mch_step |=>
    addr_q == $past(addr_q) + 11'h001)
    else $error("address counter did not step");
  dack_path_a: assert property (wr_rise && mc_en && dack_fn &&
    !pins_p_q.dack_n && mem_path_rx_allowed |=> !$stable(addr_q))
    else $error("acknowledged write missed the memory path");
  strobe_launch_a: assert property (mc_en && $past(mc_en) &&
    !$stable(addr_q) |-> $past(rd_rise || wr_rise))
    else $error("counter moved without a strobe edge");
  cpu_lock_a: assert property (mc_en && !mch_step &&
    wstb(EHB_IDX_ADDR_LO, i_cpu_sel, i_cpu_wr, i_cpu_addr)
    |=> $stable(addr_q))
    else $error("counter written while memory path on");
  tc_end_a: assert property (running && mch_wr && tc_on |=>
    mc_q == EHB_MC_END && o_cpu_irq)
    else $error("last byte did not end the transfer");
  end_hold_a: assert property (mc_q == EHB_MC_END && mc_en
    |=> $stable(addr_q))
    else $error("counter changed after transfer end");
  int_rx_a: assert property (int_sel == EHB_SEL_RX |=>
    o_host_interrupt_out == $past(rx_rdy_q))
    else $error("interrupt pin not showing rx ready");
  drq_port_a: assert property (drq_sel == EHB_DRQ_PORT |=>
    !o_dma_request_out)
    else $error("request pin active in port mode");
  burst_hold_a: assert property (burst && running && fifo_in_ready
    |=> mreq_q)
    else $error("burst request dropped during transfer");
  ram_fast_a: assert property (mch_wr && !fifo_out_valid |=>
    o_ram_req && o_ram_we && o_ram_addr == $past(addr_q) &&
    o_ram_wdata == $past(dat_p_q))
    else $error("buffer to RAM move too slow");
  off_status_a: assert property (!mc_en |=> mc_q == EHB_MC_OFF)
    else $error("status not 00 while disabled");
  rx_clear_a: assert property (!rx_en |=> !rx_rdy_q)
    else $error("rx ready kept while disabled");
  drive_a: assert property (!o_host_data_oe_n |->
    $past(!pins_s_q.rd_n))
    else $error("data driven outside a host read");

  cch_read_c: cover property (cch_rd ##[1:8] wr_buf);
  mch_write_c: cover property (mch_wr ##[1:40] mc_q == EHB_MC_END);
  mch_read_c: cover property (fetch_done ##[1:20] mch_rd);
  burst_c: cover property (burst && mreq_q [*4]);
endmodule : ehb_port

//--- tb/ehb_ram_model.sv
`timescale 1ns/10ps

module ehb_ram_model (
  input wire logic i_ref_clk,
  input wire logic i_req,
  input wire logic [10:0] i_addr,
  output logic o_grant,
  output logic [7:0] o_rdata
);
  logic [1:0] wait_q;
  integer seed_m = 32'hf18c;
  // The USB side may hold the RAM for up to two clocks per access.
  assign o_grant = i_req && wait_q == 2'h0;
  assign o_rdata = o_grant ? i_addr[7:0] ^ 8'h5a : ~i_addr[7:0];
  initial wait_q = 2'h0;
  always @(posedge i_ref_clk) begin
    if (o_grant) begin
      wait_q <= 2'($unsigned($random(seed_m)) % 3);
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule : ehb_ram_model

//--- tb/tb_external_host_bus_port.sv
`timescale 1ns/10ps

module tb_external_host_bus_port;
  import ehb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1, a0 = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
  logic dk_n = 1'b1, tc = 1'b0, a1 = 1'b0;
  logic [7:0] hdi = 8'h00, cwd = 8'h00;
  logic sel = 1'b0, crd = 1'b0, cwr = 1'b0;
  logic [3:0] caddr = 4'h0;
  logic [7:0] hdo, crdata, rwd, rrd, hd, d, s, v;
  logic hoe_n, hint, hdrq, cirq, rreq, rwe, grant, hoe, hreq;
  logic [10:0] raddr;
  ehb_ram_word_type exq[$];
  ehb_ram_word_type w;
  integer errors = 0, n_compared = 0, nirq = 0, k, i, cyc = 0;
  integer seed = 32'hf18c;

  always #25 clk = ~clk;

  ehb_port #(.FIFO_DEPTH(16)) DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_host_select_n(cs_n),
    .i_channel_select_line(a0), .i_host_read_n(rd_n),
    .i_host_write_n(wr_n), .i_dma_acknowledge_n(dk_n),
    .i_transfer_last_byte_in(tc), .i_status_read_select(a1),
    .i_host_data_bus(hdi), .o_host_data_bus(hdo),
    .o_host_data_oe_n(hoe_n), .o_host_interrupt_out(hint),
    .o_dma_request_out(hdrq), .i_cpu_sel(sel), .i_cpu_rd(crd),
    .i_cpu_wr(cwr), .i_cpu_addr(caddr), .i_cpu_wdata(cwd),
    .o_cpu_rdata(crdata), .o_cpu_irq(cirq), .o_ram_req(rreq),
    .o_ram_we(rwe), .o_ram_addr(raddr), .o_ram_wdata(rwd),
    .i_ram_grant(grant), .i_ram_rdata(rrd)
  );

  ehb_ram_model ram (
    .i_ref_clk(clk), .i_req(rreq), .i_addr(raddr),
    .o_grant(grant), .o_rdata(rrd)
  );

  task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task results;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task cw(input logic [3:0] a, input logic [7:0] x);
    @(negedge clk);
    sel = 1'b1;
    cwr = 1'b1;
    caddr = a;
    cwd = x;
    @(negedge clk);
    sel = 1'b0;
    cwr = 1'b0;
  endtask : cw

  task cr(input logic [3:0] a, output logic [7:0] x);
    @(negedge clk);
    sel = 1'b1;
    crd = 1'b1;
    caddr = a;
    @(negedge clk);
    sel = 1'b0;
    crd = 1'b0;
    x = crdata;
  endtask : cr

  // One host bus cycle; the qualifiers stay put around the strobe.
  task hc(input logic r, input logic c, input logic sa, input logic dk,
          input logic t, input logic [7:0] x);
    @(negedge clk);
    cs_n = dk;
    a0 = c;
    a1 = sa;
    dk_n = !dk;
    tc = t;
    hdi = x;
    @(negedge clk);
    if (r) rd_n = 1'b0;
    else wr_n = 1'b0;
    repeat (4) @(negedge clk);
    hd = hdo;
    hoe = hoe_n;
    hreq = hdrq;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    dk_n = 1'b1;
    a0 = 1'b0;
    a1 = 1'b0;
    tc = 1'b0;
    hdi = ~x;
    repeat (2) @(negedge clk);
  endtask : hc

  always @(negedge clk) begin
    cyc++;
    if (cirq === 1'b1) nirq++;
    if (rreq === 1'b1 && rwe === 1'b1 && grant === 1'b1) begin
      if (exq.size() == 0) begin
        chk("extra ram write", 11'h000, 11'h001);
      end else begin
        w = exq.pop_front();
        chk("ram addr", w.addr, raddr);
        chk("ram data", {3'h0, w.data}, {3'h0, rwd});
      end
    end
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("oe_n reset", 1, hoe_n);
    chk("dreq port", 0, hdrq);
    cr(EHB_IDX_STATUS, d);
    chk("status reset", 0, d);
    cw(EHB_IDX_ENABLE, 8'h03);
    cw(EHB_IDX_CFG_LO, 8'h02);
    v = 8'($random(seed));
    k = nirq;
    hc(0, 1, 0, 0, 0, v);
    chk("irq on write", k + 1, nirq);
    chk("int pin rx", 1, hint);
    cr(EHB_IDX_STATUS, d);
    chk("rx ready", 1, d[0]);
    cr(EHB_IDX_BUF, d);
    chk("rx byte", v, d);
    cr(EHB_IDX_STATUS, d);
    chk("rx clear", 0, d[0]);
    cw(EHB_IDX_ENABLE, 8'h02);
    k = nirq;
    hc(0, 1, 0, 0, 0, ~v);
    chk("irq refused", k, nirq);
    v = 8'($random(seed));
    cw(EHB_IDX_BUF, v);
    cw(EHB_IDX_CFG_LO, 8'h00);
    k = nirq;
    hc(1, 1, 1, 0, 0, 8'h00);
    chk("host read", v, hd);
    chk("oe in read", 0, hoe);
    chk("oe after", 1, hoe_n);
    chk("irq on read", k + 1, nirq);
    cw(EHB_IDX_CFG_LO, 8'h10);
    cr(EHB_IDX_STATUS, s);
    hc(1, 0, 1, 0, 0, 8'h00);
    chk("status on bus", s, hd);
    // Start and end are set before the memory path is enabled.
    cw(EHB_IDX_CFG_HI, 8'h02);
    cw(EHB_IDX_ADDR_LO, 8'h0a);
    cw(EHB_IDX_ADDR_HI, 8'h01);
    cw(EHB_IDX_END_LO, 8'h0d);
    cw(EHB_IDX_END_HI, 8'h01);
    cw(EHB_IDX_MODE, 8'h01);
    cw(EHB_IDX_ENABLE, 8'h04);
    repeat (3) @(negedge clk);
    chk("drq idle", 1, hdrq);
    k = nirq;
    for (i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      if (i < 4) exq.push_back({11'(11'h10a + i), v});
      hc(0, 0, 0, 0, 0, v);
      chk("drq in strobe", 0, hreq);
    end
    repeat (10) @(negedge clk);
    chk("ram writes left", 0, 11'(exq.size()));
    chk("end irq", k + 1, nirq);
    cr(EHB_IDX_STATUS, d);
    chk("end status", 3, d[3:2]);
    cw(EHB_IDX_ADDR_LO, 8'h55);
    cr(EHB_IDX_ADDR_LO, d);
    chk("counter kept", 8'h0e, d);
    cw(EHB_IDX_ENABLE, 8'h00);
    cr(EHB_IDX_STATUS, d);
    chk("off status", 0, d[3:2]);
    cw(EHB_IDX_CFG_HI, 8'h0e);
    cw(EHB_IDX_ADDR_LO, 8'h20);
    cw(EHB_IDX_ADDR_HI, 8'h00);
    cw(EHB_IDX_END_LO, 8'h28);
    cw(EHB_IDX_END_HI, 8'h00);
    cw(EHB_IDX_MODE, 8'h05);
    cw(EHB_IDX_ENABLE, 8'h04);
    // Acknowledge cycles keep the channel line low.
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      if (i < 3) exq.push_back({11'(11'h020 + i), v});
      hc(0, 0, 0, 1, i == 2, v);
      if (i < 2) chk("burst drq", 1, hreq);
    end
    repeat (10) @(negedge clk);
    chk("dack writes left", 0, 11'(exq.size()));
    cr(EHB_IDX_STATUS, d);
    chk("last byte status", 3, d[3:2]);
    cr(EHB_IDX_ADDR_LO, d);
    chk("last counter", 8'h23, d);
    // Cycle-mode memory reads; the RAM model returns address xor 5a.
    cw(EHB_IDX_ENABLE, 8'h00);
    cw(EHB_IDX_CFG_LO, 8'h04);
    cw(EHB_IDX_ADDR_LO, 8'h30);
    cw(EHB_IDX_END_LO, 8'h31);
    cw(EHB_IDX_MODE, 8'h02);
    cw(EHB_IDX_ENABLE, 8'h04);
    repeat (8) @(negedge clk);
    chk("int pin mreq", 1, hint);
    cw(EHB_IDX_BUF, 8'hff);
    k = nirq;
    for (i = 0; i < 2; i++) begin
      hc(1, 0, 0, 0, 0, 8'h00);
      chk("ram read byte", 8'(8'h30 + i) ^ 8'h5a, hd);
      chk("drq in read", 0, hreq);
    end
    chk("read end irq", k + 1, nirq);
    cr(EHB_IDX_STATUS, d);
    chk("read end status", 3, d[3:2]);
    cr(EHB_IDX_ADDR_LO, d);
    chk("read counter", 8'h32, d);
    results();
  end
endmodule : tb_external_host_bus_port
